// ==== inc/dspcp_pkg.sv ====
/*
 * shared constants, address map and framing helpers for the control port.
 * assumes both ends run on sys_clk and agree on the chip address.
 */
//------------------------------------------------------------
// Function
// - 1x rate runs 1024 instructions per sample
// - 2x rate runs 512 instructions, 96 kHz
// - 4x rate runs 256 instructions, 192 kHz
// - eight 32-bit save slots, 28-bit zero-padded
// - slots refreshed from parameter words every sample
// - configurable trigger edge dumps slots to EEPROM
// - control bit 6: host writes slots, core stops
// - data fields zero-extended to whole bytes
// - three-byte header: chip, direction, address
// - data byte count follows from target address
// - single writes span four to eight bytes
// - burst continues data words; latch ends it
// - burst address increments across all regions
// - parameter words: padded address, 28-bit data
// - program words: address, then 40-bit word
// - core/serial-out controls: two bytes, MSB first
// - memory-config/serial-in controls: one byte
// - capture setup: step index then source select
// - capture read returns three data bytes
// - safe-update address: padded 10-bit address
// - safe-update data: zero byte, 28-bit data
// - 2k data memory unreachable from host port
//------------------------------------------------------------
package dspcp_pkg;
	localparam logic [6:0] CHIP_ADDR = 7'h34; // arbitrary value
	localparam logic [11:0] A_PROG = 12'h400;
	localparam logic [11:0] A_IFACE = 12'h800;
	localparam logic [11:0] A_SAFE_DATA = 12'h810;
	localparam logic [11:0] A_SAFE_ADR = 12'h815;
	localparam logic [11:0] A_CAP0 = 12'h81A;
	localparam logic [11:0] A_CAP1 = 12'h81B;
	localparam logic [11:0] A_CORE = 12'h81C;
	localparam logic [11:0] A_MEMCFG = 12'h81D;
	localparam logic [11:0] A_SIN = 12'h81F;
	localparam logic [11:0] A_MP0 = 12'h820;
	localparam logic [11:0] A_MP1 = 12'h821;
	localparam int CORE_IFACE_WR_BIT = 6;
	localparam logic [15:0] CORE_RST = 16'h0000;
	localparam logic [10:0] INSTR_1X = 11'h400;
	localparam int SLOT_COUNT = 8;
	localparam int DRAM_WORDS = 2048;
	localparam int SCLK_HALF_CYC = 8;
	// host command port offsets
	localparam logic [7:0] H_CMD = 8'h00;
	localparam logic [7:0] H_DLO = 8'h04;
	localparam logic [7:0] H_DHI = 8'h08;
	localparam logic [7:0] H_NEXT = 8'h0C;
	localparam logic [7:0] H_STAT = 8'h10;
	localparam logic [7:0] H_RLO = 8'h14;
	localparam logic [7:0] H_RHI = 8'h18;

	// data bytes that follow the header for a target address
	function automatic logic [2:0] dspcp_len(input logic [11:0] a, input logic rd);
		if (a < A_PROG) return 3'd4;
		if (a < A_IFACE) return 3'd5;
		if (a < A_IFACE + 12'h008) return 3'd4;
		if (a >= A_SAFE_DATA && a < A_SAFE_ADR) return 3'd5;
		if (a == A_CAP0 || a == A_CAP1) return rd ? 3'd3 : 3'd2;
		if (a == A_MEMCFG || a == A_SIN) return 3'd1;
		if (a == A_MP0 || a == A_MP1) return 3'd3;
		return 3'd2;
	endfunction : dspcp_len

	// left-justify a right-aligned word of len bytes in 40 bits
	function automatic logic [39:0] dspcp_align(input logic [39:0] w, input logic [2:0] len);
		return w << (6'(5 - len) * 6'd8);
	endfunction : dspcp_align
endpackage : dspcp_pkg

// ==== inc/dspcp_if.sv ====
/*
 * four-wire serial control link between host and device.
 * assumes the testbench joins both modports; only miso has an enable.
 */
`timescale 1ns/1ps
interface dspcp_if;
	logic sclk;
	logic mosi;
	logic latch_n;
	logic miso;
	logic miso_oe;
	modport dev(input sclk, input mosi, input latch_n, output miso, output miso_oe);
	modport host(output sclk, output mosi, output latch_n, input miso, input miso_oe);
endinterface : dspcp_if

// ==== core/dspcp_sync.sv ====
/*
 * two-flop synchroniser for a group of independent levels.
 * assumes each bit is a slow level from another domain.
 */
`timescale 1ns/1ps
module dspcp_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// levels
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	// only the second stage is read outside
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule : dspcp_sync

// ==== core/dspcp_device.sv ====
/*
 * device end: serial frame decoder, save slots, core control,
 * sample sequencer, probe capture and parameter/program stores.
 * assumes link pins are asynchronous to sys_clk and sclk is slow.
 */
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module dspcp_device
	import dspcp_pkg::*;
#(
	parameter logic [9:0] SLOT_PARAM_BASE = 10'h000
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// serial link
	dspcp_if.dev lnk,
	// core probes and sequencing
	input wire logic [3:0][23:0] probe_data,
	output logic sample_tick,
	output logic [10:0] instr_budget,
	output logic [15:0] core_ctl,
	// parameter save
	input wire logic save_trig,
	input wire logic save_edge_rise,
	output logic save_valid,
	output logic [2:0] save_index,
	output logic [31:0] save_word,
	// audio data memory, core side only
	input wire logic dram_we,
	input wire logic [10:0] dram_addr,
	input wire logic [23:0] dram_wdata,
	output logic [23:0] dram_rdata
);
	import dspcp_pkg::*;

	typedef enum logic [2:0] {ST_CHIP, ST_AH, ST_AL, ST_DATA, ST_SKIP} dspcp_st_e;
	typedef struct packed {
		dspcp_st_e st;
		logic [2:0] bitc;
		logic [7:0] sh;
		logic [2:0] bytec;
		logic [39:0] acc;
		logic [11:0] adr;
		logic rd;
		logic [39:0] tx;
		logic miso;
		logic oe;
		logic sclk_d;
		logic [9:0] step;
		logic tick;
		logic [15:0] ctl;
		logic [1:0][12:0] cap_set;
		logic [1:0][23:0] cap;
		logic [7:0][31:0] slot;
		logic trig_d;
		logic [3:0] save_cnt;
		logic save_valid;
		logic [2:0] save_idx;
		logic [31:0] save_word;
	} dspcp_dev_s;

	dspcp_dev_s s_r, s_nxt;
	logic [3:0] pins;
	logic sclk_s, mosi_s, latch_s, trig_s;
	logic wr_en;
	logic [11:0] wr_a;
	logic [39:0] wr_d;
	logic [27:0] pmem [0:1023];
	logic [39:0] prog_mem [0:1023];
	logic [23:0] dmem [0:DRAM_WORDS-1];

	// every link input, trigger included, crosses through two flops
	dspcp_sync #(.W(4)) u_sync (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.d({save_trig, lnk.latch_n, lnk.mosi, lnk.sclk}),
		.q(pins)
	);
	assign {trig_s, latch_s, mosi_s, sclk_s} = pins;

	// readback of a target; unmapped or write-only targets read zero
	function automatic logic [39:0] rd_word(input dspcp_dev_s s, input logic [11:0] a);
		if (a < A_PROG) return {12'h000, pmem[a[9:0]]};
		if (a < A_IFACE) return prog_mem[a[9:0]];
		if (a < A_IFACE + 12'h008) return {8'h00, s.slot[a[2:0]]};
		if (a == A_CAP0) return {16'h0000, s.cap[0]};
		if (a == A_CAP1) return {16'h0000, s.cap[1]};
		if (a == A_CORE) return {24'h000000, s.ctl};
		return '0;
	endfunction : rd_word

	// sequencer budget: reserved code 11 falls back to the 1x budget
	always_comb begin
		unique case (s_r.ctl[1:0])
			2'b01: instr_budget = INSTR_1X >> 1;
			2'b10: instr_budget = INSTR_1X >> 2;
			default: instr_budget = INSTR_1X;
		endcase
	end

	// frame decoding, register writes, sequencing and save dump
	always_comb begin
		logic [7:0] b;
		logic [2:0] len;
		logic [11:0] na;
		logic rise;
		logic fall;
		logic edge_hit;
		b = {s_r.sh[6:0], mosi_s};
		edge_hit = save_edge_rise ? (trig_s & ~s_r.trig_d) : (~trig_s & s_r.trig_d);
		len = dspcp_len(s_r.adr, s_r.rd);
		na = s_r.adr + 12'h001;
		rise = sclk_s & ~s_r.sclk_d;
		fall = ~sclk_s & s_r.sclk_d;
		s_nxt = s_r;
		s_nxt.sclk_d = sclk_s;
		wr_en = 1'b0;
		wr_a = s_r.adr;
		wr_d = {s_r.acc[31:0], b};
		if (latch_s) begin
			// latch high ends any frame, single or burst
			s_nxt.st = ST_CHIP;
			s_nxt.bitc = 3'd0;
			s_nxt.oe = 1'b0;
			s_nxt.miso = 1'b0;
		end else if (rise) begin
			s_nxt.sh = b;
			s_nxt.bitc = s_r.bitc + 3'd1;
			if (s_r.bitc == 3'd7) begin
				unique case (s_r.st)
					ST_CHIP: begin
						s_nxt.rd = b[0];
						s_nxt.st = (b[7:1] == CHIP_ADDR) ? ST_AH : ST_SKIP;
					end
					ST_AH: begin
						s_nxt.adr[11:8] = b[3:0];
						s_nxt.st = ST_AL;
					end
					ST_AL: begin
						s_nxt.adr[7:0] = b;
						s_nxt.st = ST_DATA;
						s_nxt.bytec = 3'd0;
						s_nxt.acc = '0;
						if (s_r.rd) begin
							// length known from the address alone
							s_nxt.tx = dspcp_align(rd_word(s_r, {s_r.adr[11:8], b}),
								dspcp_len({s_r.adr[11:8], b}, 1'b1));
							s_nxt.oe = 1'b1;
						end
					end
					ST_DATA: begin
						s_nxt.acc = wr_d;
						s_nxt.bytec = s_r.bytec + 3'd1;
						if (s_r.bytec + 3'd1 == len) begin
							wr_en = ~s_r.rd;
							s_nxt.adr = na;
							s_nxt.bytec = 3'd0;
							s_nxt.acc = '0;
							if (s_r.rd) begin
								s_nxt.tx = dspcp_align(rd_word(s_r, na), dspcp_len(na, 1'b1));
							end
						end
					end
					default: s_nxt.st = ST_SKIP;
				endcase
			end
		end else if (fall && s_r.oe) begin
			s_nxt.miso = s_r.tx[39];
			s_nxt.tx = {s_r.tx[38:0], 1'b0};
		end
		// register targets; memories are written in their own process
		if (wr_en) begin
			if (wr_a == A_CORE) begin
				s_nxt.ctl = wr_d[15:0];
			end
			if (wr_a == A_CAP0 || wr_a == A_CAP1) begin
				s_nxt.cap_set[wr_a[0]] = wr_d[12:0];
			end
			if (wr_a >= A_IFACE && wr_a < A_IFACE + 12'h008 && s_r.ctl[CORE_IFACE_WR_BIT]) begin
				s_nxt.slot[wr_a[2:0]] = {4'h0, wr_d[27:0]};
			end
		end
		// instruction step counter, one instruction per clock
		s_nxt.tick = 1'b0;
		if ({1'b0, s_r.step} >= instr_budget - 11'd1) begin
			s_nxt.step = '0;
			s_nxt.tick = 1'b1;
		end else begin
			s_nxt.step = s_r.step + 10'd1;
		end
		// slot i refreshed at step i, so each slot once per sample
		if (!s_r.ctl[CORE_IFACE_WR_BIT] && s_r.step < 10'(SLOT_COUNT)) begin
			s_nxt.slot[s_r.step[2:0]] = {4'h0, pmem[SLOT_PARAM_BASE + s_r.step]};
		end
		// capture when the step reaches the programmed index
		for (int c = 0; c < 2; c++) begin
			if ({1'b0, s_r.step} == s_r.cap_set[c][12:2]) begin
				s_nxt.cap[c] = probe_data[s_r.cap_set[c][1:0]];
			end
		end
		// save dump: one slot per clock, retrigger ignored while busy
		s_nxt.trig_d = trig_s;
		s_nxt.save_valid = 1'b0;
		if (s_r.save_cnt != 4'd0) begin
			s_nxt.save_valid = 1'b1;
			s_nxt.save_idx = 3'(4'd8 - s_r.save_cnt);
			s_nxt.save_word = s_r.slot[3'(4'd8 - s_r.save_cnt)];
			s_nxt.save_cnt = s_r.save_cnt - 4'd1;
		end else if (edge_hit) begin
			s_nxt.save_cnt = 4'd8;
		end
	end

	// state register
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			s_r <= '0;
			s_r.st <= ST_CHIP;
			s_r.ctl <= CORE_RST;
			s_r.sclk_d <= 1'b0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// parameter and program stores, no reset on memory contents
	always_ff @(posedge sys_clk) begin
		if (wr_en && wr_a < A_PROG) begin
			pmem[wr_a[9:0]] <= wr_d[27:0];
		end
		if (wr_en && wr_a >= A_PROG && wr_a < A_IFACE) begin
			prog_mem[wr_a[9:0]] <= wr_d;
		end
	end

	// data memory has no decode from the link at all
	always_ff @(posedge sys_clk) begin
		if (dram_we) begin
			dmem[dram_addr] <= dram_wdata;
		end
		dram_rdata <= dmem[dram_addr];
	end

	assign lnk.miso = s_r.miso;
	assign lnk.miso_oe = s_r.oe;
	assign sample_tick = s_r.tick;
	assign core_ctl = s_r.ctl;
	assign save_valid = s_r.save_valid;
	assign save_index = s_r.save_idx;
	assign save_word = s_r.save_word;
endmodule : dspcp_device

// ==== core/dspcp_host.sv ====
/*
 * host end: frames header and data words onto the link from a
 * small command register set. assumes the device answers on miso.
 */
`timescale 1ns/1ps
module dspcp_host
	import dspcp_pkg::*;
#(
	parameter int HALF = SCLK_HALF_CYC
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// command port
	input wire logic [7:0] cmd_addr,
	input wire logic [31:0] cmd_wdata,
	input wire logic cmd_wr,
	input wire logic cmd_rd,
	output logic [31:0] cmd_rdata,
	// serial link
	dspcp_if.host lnk
);
	import dspcp_pkg::*;

	typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_END, H_HOLD} dspcp_hst_e;
	typedef struct packed {
		dspcp_hst_e st;
		logic [7:0] div;
		logic sclk;
		logic [63:0] sh;
		logic [6:0] nbits;
		logic [11:0] adr;
		logic rw;
		logic more;
		logic [31:0] dlo;
		logic [7:0] dhi;
		logic [39:0] rx;
		logic latch_n;
		logic [31:0] rdata;
	} dspcp_host_s;

	dspcp_host_s s_r, s_nxt;
	logic miso_s;

	// miso crosses from the device like any other pin
	dspcp_sync #(.W(1)) u_sync (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.d(lnk.miso),
		.q(miso_s)
	);

	// command decode, frame sequencing and clock divider
	always_comb begin
		logic [2:0] len;
		logic half;
		len = dspcp_len(s_r.adr, s_r.rw);
		half = (s_r.div == 8'(HALF - 1));
		s_nxt = s_r;
		s_nxt.div = half ? 8'd0 : s_r.div + 8'd1;
		if (cmd_wr && cmd_addr == H_DLO) begin
			s_nxt.dlo = cmd_wdata;
		end
		if (cmd_wr && cmd_addr == H_DHI) begin
			s_nxt.dhi = cmd_wdata[7:0];
		end
		unique case (s_r.st)
			H_IDLE: begin
				if (cmd_wr && cmd_addr == H_CMD) begin
					// header first, then one padded data word; bit 14 flips the
					// chip address so a frame can be aimed at a foreign chip
					s_nxt.adr = cmd_wdata[11:0];
					s_nxt.rw = cmd_wdata[12];
					s_nxt.more = cmd_wdata[13];
					s_nxt.sh = {CHIP_ADDR ^ {6'h00, cmd_wdata[14]}, cmd_wdata[12], 4'h0,
						cmd_wdata[11:0],
						dspcp_align({s_r.dhi, s_r.dlo}, dspcp_len(cmd_wdata[11:0],
						cmd_wdata[12]))};
					s_nxt.nbits = 7'd24 + 7'(dspcp_len(cmd_wdata[11:0], cmd_wdata[12])) * 7'd8;
					s_nxt.latch_n = 1'b0;
					s_nxt.div = 8'd0;
					s_nxt.st = H_SHIFT;
				end
			end
			H_SHIFT: begin
				if (half) begin
					s_nxt.sclk = ~s_r.sclk;
					if (!s_r.sclk) begin
						s_nxt.rx = {s_r.rx[38:0], miso_s};
						s_nxt.nbits = s_r.nbits - 7'd1;
					end else begin
						s_nxt.sh = {s_r.sh[62:0], 1'b0};
						if (s_r.nbits == 7'd0) begin
							s_nxt.st = H_END;
						end
					end
				end
			end
			H_END: begin
				if (half) begin
					s_nxt.adr = s_r.adr + 12'h001;
					s_nxt.latch_n = ~s_r.more;
					s_nxt.st = s_r.more ? H_HOLD : H_IDLE;
				end
			end
			H_HOLD: begin
				// next word goes out with no header; 0 closes the frame
				if (cmd_wr && cmd_addr == H_NEXT) begin
					if (cmd_wdata[0]) begin
						s_nxt.more = cmd_wdata[1];
						s_nxt.sh = {dspcp_align({s_r.dhi, s_r.dlo}, len), 24'h000000};
						s_nxt.nbits = 7'(len) * 7'd8;
						s_nxt.div = 8'd0;
						s_nxt.st = H_SHIFT;
					end else begin
						s_nxt.latch_n = 1'b1;
						s_nxt.st = H_IDLE;
					end
				end
			end
		endcase
		// read data stands only in the cycle after the strobe
		s_nxt.rdata = '0;
		if (cmd_rd) begin
			unique case (cmd_addr)
				H_DLO: s_nxt.rdata = s_r.dlo;
				H_DHI: s_nxt.rdata = {24'h000000, s_r.dhi};
				H_STAT: s_nxt.rdata = {30'h0, s_r.st == H_HOLD,
					s_r.st == H_SHIFT || s_r.st == H_END};
				H_RLO: s_nxt.rdata = s_r.rx[31:0];
				H_RHI: s_nxt.rdata = {24'h000000, s_r.rx[39:32]};
				H_CMD: s_nxt.rdata = {18'h0, s_r.more, s_r.rw, s_r.adr};
				default: s_nxt.rdata = '0;
			endcase
		end
	end

	// state register
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			s_r <= '0;
			s_r.st <= H_IDLE;
			s_r.latch_n <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign lnk.sclk = s_r.sclk;
	assign lnk.mosi = s_r.sh[63];
	assign lnk.latch_n = s_r.latch_n;
	assign cmd_rdata = s_r.rdata;
endmodule : dspcp_host

// ==== test/dspcp_checker.sv ====
/*
 * link checker: timing and framing of the serial control link.
 * assumes the host makes sclk with the default half period of 8 clocks.
 */
`timescale 1ns/1ps
module dspcp_checker (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// serial link
	input wire logic sclk,
	input wire logic mosi,
	input wire logic latch_n,
	input wire logic miso,
	input wire logic miso_oe
);
	logic sclk_r;
	logic [9:0] rise_r;
	logic [9:0] rise_nxt;

	// one counter of sclk rises per frame serves every length check
	always_comb begin
		rise_nxt = latch_n ? 10'h000 : rise_r + 10'(sclk & ~sclk_r);
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			sclk_r <= 1'b0;
			rise_r <= 10'h000;
		end else begin
			sclk_r <= sclk;
			rise_r <= rise_nxt;
		end
	end

	// ----------------------------------------
	// link properties
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	a_idle_clock_low: assert property (latch_n |-> !sclk)
		else $error("link clock runs outside a frame");
	a_clock_half: assert property ($rose(sclk) |-> sclk[*8] ##1 !sclk)
		else $error("link clock high phase has the wrong length");
	a_mosi_hold: assert property (sclk && $past(sclk) |-> $stable(mosi))
		else $error("host data moved while link clock high");
	a_miso_hold: assert property (miso_oe && sclk && $past(sclk) |-> $stable(miso))
		else $error("device data moved while link clock high");
	a_answer_late: assert property ($rose(miso_oe) |-> !latch_n && rise_r >= 10'd24)
		else $error("device drove before the header ended");
	a_oe_released: assert property (latch_n[*5] |-> !miso_oe)
		else $error("device still drives after frame end");
	a_whole_bytes: assert property ($rose(latch_n) |-> rise_r[2:0] == 3'h0 && rise_r >= 10'd32)
		else $error("frame did not hold whole bytes");
	a_latch_quiet: assert property ($rose(latch_n) |-> !$past(sclk, 4))
		else $error("frame closed too close to a clock edge");

	cover property ($rose(miso_oe));
	cover property ($rose(latch_n) && rise_r == 10'd32);
	cover property ($rose(latch_n) && rise_r > 10'd64);
endmodule : dspcp_checker

// ==== test/dsp_control_port_framing_test.sv ====
/*
 * bench: host and device joined over the link, driven by command port.
 * assumes default sclk half period and the package address map.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; \
	$display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module dsp_control_port_framing_test;
	import dspcp_pkg::*;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] cmd_addr = 8'h00;
	logic [31:0] cmd_wdata = 32'h0;
	logic cmd_wr = 1'b0;
	logic cmd_rd = 1'b0;
	logic [31:0] cmd_rdata;
	logic [3:0][23:0] probe_data = {24'hD4C3B2, 24'hC3B2A1, 24'hB2A190, 24'hA1908F};
	logic save_trig = 1'b0;
	logic save_edge_rise = 1'b1;
	logic dram_we = 1'b0;
	logic [10:0] dram_addr = 11'h000;
	logic [23:0] dram_wdata = 24'h0;
	logic sample_tick, save_valid;
	logic [10:0] instr_budget;
	logic [15:0] core_ctl;
	logic [2:0] save_index;
	logic [31:0] save_word;
	logic [23:0] dram_rdata;
	logic [10:0] bud [4] = '{11'h400, 11'h200, 11'h100, 11'h400};
	int err_total = 0;
	int num_checks = 0;
	int i, k, n, gap;

	always #25 sys_clk = ~sys_clk;

	dspcp_if lnk();
	dspcp_host u_dspcp_host (.sys_clk(sys_clk), .resetn(resetn), .cmd_addr(cmd_addr),
		.cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata),
		.lnk(lnk));
	dspcp_device u_dspcp_device (.sys_clk(sys_clk), .resetn(resetn), .lnk(lnk),
		.probe_data(probe_data), .sample_tick(sample_tick), .instr_budget(instr_budget),
		.core_ctl(core_ctl), .save_trig(save_trig), .save_edge_rise(save_edge_rise),
		.save_valid(save_valid), .save_index(save_index), .save_word(save_word),
		.dram_we(dram_we), .dram_addr(dram_addr), .dram_wdata(dram_wdata),
		.dram_rdata(dram_rdata));
	dspcp_checker u_dspcp_checker (.sys_clk(sys_clk), .resetn(resetn), .sclk(lnk.sclk),
		.mosi(lnk.mosi), .latch_n(lnk.latch_n), .miso(lnk.miso), .miso_oe(lnk.miso_oe));

	// ----------------------------------------
	// command port tasks
	// ----------------------------------------
	task automatic conclude();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : conclude

	task automatic put(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		cmd_wr <= 1'b1;
		cmd_addr <= a;
		cmd_wdata <= d;
		@(posedge sys_clk);
		cmd_wr <= 1'b0;
	endtask : put

	task automatic get(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		cmd_rd <= 1'b1;
		cmd_addr <= a;
		@(posedge sys_clk);
		cmd_rd <= 1'b0;
		#1 d = cmd_rdata;
	endtask : get

	// poll busy under a bound; a hung link ends the run
	task automatic settle();
		logic [31:0] s;
		s = 32'h1;
		for (int j = 0; j < 4000 && s[0] !== 1'b0; j++) get(H_STAT, s);
		if (s[0] !== 1'b0) begin
			err_total++;
			conclude();
		end
	endtask : settle

	// cycles from one sample tick to the next; a missing tick ends the run
	task automatic tick_gap(output int g);
		for (int j = 0; j < 3000 && sample_tick !== 1'b1; j++) @(negedge sys_clk);
		@(negedge sys_clk);
		for (g = 1; g < 3000 && sample_tick !== 1'b1; g++) @(negedge sys_clk);
		if (g == 3000) begin
			err_total++;
			conclude();
		end
	endtask : tick_gap

	// mode bit 1 keeps the frame open, bit 0 reads
	task automatic frame(input logic [11:0] a, input logic [1:0] mode, input logic [39:0] w);
		put(H_DLO, w[31:0]);
		put(H_DHI, {24'h0, w[39:32]});
		put(H_CMD, {18'h0, mode, a});
		settle();
	endtask : frame

	// only the low nb bytes of the answer are defined
	task automatic rdback(input logic [11:0] a, input logic [39:0] e, input int nb);
		logic [31:0] lo;
		logic [31:0] hi;
		logic [39:0] m;
		m = (40'h1 << (8 * nb)) - 40'h1;
		frame(a, 2'b01, 40'h0);
		get(H_RLO, lo);
		get(H_RHI, hi);
		`CHK({hi[7:0], lo} & m, e)
	endtask : rdback

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (12) @(posedge sys_clk);
		resetn <= 1'b1;
		// every sample-rate code, reserved one included
		for (i = 0; i < 4; i++) begin
			frame(A_CORE, 2'b00, 40'(i));
			`CHK(core_ctl, 16'(i))
			`CHK(instr_budget, bud[i])
			rdback(A_CORE, 40'(i), 2);
			tick_gap(gap);
			`CHK(gap, 32'(bud[i]))
		end
		frame(A_CORE, 2'b00, 40'h0);
		// burst crosses from the last parameter word into program memory
		frame(A_PROG - 12'h1, 2'b10, 40'h000ABCDEF1);
		put(H_DLO, 32'h3456789A);
		put(H_DHI, 32'h12);
		put(H_NEXT, 32'h1);
		settle();
		rdback(A_PROG - 12'h1, 40'h000ABCDEF1, 4);
		rdback(A_PROG, 40'h123456789A, 5);
		// slot 0 follows parameter word 0 while bit 6 is clear
		frame(12'h000, 2'b00, 40'h01234567);
		repeat (2100) @(posedge sys_clk);
		rdback(A_IFACE, 40'h01234567, 4);
		// host ownership: later parameter changes no longer reach the slot
		frame(A_CORE, 2'b00, 40'h40);
		frame(A_IFACE + 12'h7, 2'b00, 40'h0FEDCBA9);
		frame(12'h000, 2'b00, 40'h0);
		repeat (2100) @(posedge sys_clk);
		rdback(A_IFACE, 40'h01234567, 4);
		rdback(A_IFACE + 12'h7, 40'h0FEDCBA9, 4);
		// a frame for another chip must leave the core control alone
		put(H_DLO, 32'h00000002);
		put(H_CMD, {17'h0, 1'b1, 2'b00, A_CORE});
		settle();
		`CHK(core_ctl, 16'h0040)
		// dump on a rising edge, then on a falling edge
		for (i = 0; i < 2; i++) begin
			@(posedge sys_clk);
			save_edge_rise <= !i[0];
			repeat (4) @(posedge sys_clk);
			save_trig <= !i[0];
			for (n = 0; n < 50 && save_valid !== 1'b1; n++) @(negedge sys_clk);
			if (n == 50) begin
				err_total++;
				conclude();
			end
			for (k = 0; k < 8; k++) begin
				`CHK(save_valid, 1'b1)
				`CHK(save_index, 3'(k))
				if (k == 0) `CHK(save_word, 32'h01234567)
				if (k == 7) `CHK(save_word, 32'h0FEDCBA9)
				@(negedge sys_clk);
			end
		end
		// capture at step 5 from every probe source
		for (i = 0; i < 4; i++) begin
			frame(A_CAP0, 2'b00, 40'((5 << 2) | i));
			repeat (2100) @(posedge sys_clk);
			rdback(A_CAP0, 40'(probe_data[i]), 3);
		end
		// data memory answers its core port only
		@(posedge sys_clk);
		dram_we <= 1'b1;
		dram_addr <= 11'h7FF;
		dram_wdata <= 24'h5A5A5A;
		@(posedge sys_clk);
		dram_we <= 1'b0;
		@(posedge sys_clk);
		@(negedge sys_clk);
		`CHK(dram_rdata, 24'h5A5A5A)
		conclude();
	end
endmodule : dsp_control_port_framing_test
